//--- hw/uph_defines.svh
// Register numbers, field positions and timing for the host pin block
`ifndef UPH_DEFINES_SVH
`define UPH_DEFINES_SVH

// Register numbers as carried in the command byte
`define UPH_REG_USB_IRQ    5'h0D
`define UPH_REG_USB_IEN    5'h0E
`define UPH_REG_BUS_CTL    5'h0F
`define UPH_REG_HOST_CTL   5'h10
`define UPH_REG_PIN_CFG    5'h11
`define UPH_REG_IO_PINS    5'h14
`define UPH_REG_LAST_FIFO  5'h04
`define UPH_REG_LAST       5'h14
`define UPH_REG_STEP       5'h01

// Command byte fields
`define UPH_CMD_ADDR_HI    7
`define UPH_CMD_ADDR_LO    3
`define UPH_CMD_WR_BIT     1

// Pin configuration fields
`define UPH_PC_FDUP        4
`define UPH_PC_LEVEL       3
`define UPH_PC_POSINT      2
`define UPH_PC_MUX_HI      1
`define UPH_PC_MUX_LO      0

// Bus interrupt flags, host control fields, pin register split
`define UPH_IRQ_VBUS       6
`define UPH_IRQ_NOVBUS     5
`define UPH_HC_IE          0
`define UPH_HC_SUPPLY      7
`define UPH_GPO_HI         3
`define UPH_GPI_HI         7
`define UPH_GPI_LO         4

// Bit counter
`define UPH_BIT_FIRST      3'h0
`define UPH_BIT_LAST       3'h7
`define UPH_BIT_STEP       3'h1
`define UPH_MSB            7

// Timing: edge-mode interrupt pulse, least time rounded up
`define UPH_MCLK_MHZ       200
`define UPH_INT_PULSE_NS   20
`define UPH_INT_PULSE_CYC  \
  ((`UPH_INT_PULSE_NS * `UPH_MCLK_MHZ + 999) / 1000)
`define UPH_PCNT_W         8
`define UPH_PCNT_ONE       8'h01

`endif

//--- hw/uph_pkg.sv
// Types for the host pin block
package uph_pkg;

  typedef enum logic [1:0] {
    MUX_OSC    = 2'b00,
    MUX_SUPPLY = 2'b01,
    MUX_ACT    = 2'b10,
    MUX_SOF    = 2'b11
  } uph_mux_t;

  // Frozen copy of every readable byte, handed to the link domain
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] usb_irq;
    logic [7:0] usb_ien;
    logic [7:0] bus_ctl;
    logic [7:0] host_ctl;
    logic [7:0] pin_cfg;
    logic [7:0] io_pins;
  } uph_snap_t;

  typedef struct packed {
    logic [1:0] ss_s;
    logic [1:0] clr_s;
    logic [1:0] sup_s;
    logic [1:0] vb_s;
    logic [2:0] wt_s;
    logic [3:0] gi_a;
    logic [3:0] gi_b;
    logic       vb_prev;
    logic       lnk_rst;
    logic [7:0] usb_irq;
    logic [7:0] usb_ien;
    logic [7:0] bus_ctl;
    logic       host_ie;
    logic [7:0] pin_cfg;
    logic [3:0] gpo;
    logic       pend_prev;
    logic [7:0] pcnt;
    logic       mux;
    logic       int_o;
    logic       int_oe;
    uph_snap_t  snap;
  } uph_core_t;

  typedef struct packed {
    logic       first;
    logic [2:0] bitc;
    logic [6:0] sh;
    logic [4:0] addr;
    logic       dir;
  } uph_rx_t;

  typedef struct packed {
    logic       tog;
    logic [4:0] addr;
    logic [7:0] data;
  } uph_hs_t;

  typedef struct packed {
    logic dout;
    logic oe;
  } uph_tx_t;

endpackage : uph_pkg

//--- hw/uph_pins.sv
// Host-side pin logic: SPI slave framing, data pins, GPIO, mux and interrupt
//
// Behaviour
// - Chip-clear low clears all registers but pin config, bus control, SPI.
// - Incoming serial data is sampled on rising serial clock.
// - Outgoing serial data changes on falling serial clock.
// - Slave-select high deselects the slave; clock edges are ignored.
// - A transfer runs from slave-select falling to slave-select rising.
// - MISO is driven only when selected in full duplex, else released.
// - Half duplex: MOSI carries read data back; master releases it.
// - Mux output shows oscillator, supply, activity or frame start.
// - Edge mode: interrupt pin push-pull with selectable polarity.
// - Level mode: interrupt pin open-drain, low while enabled irq pending.
// - Interrupt pin stays inactive until the pin enable bit is set.
// - General outputs follow bits 3..0 last written to the pin register.
// - Bits 7..4 of the pin register read the general input levels.
// - Writes to the general input bits are ignored.
// - Supply comparator state is a readable bit and raises interrupts.
// - Without supply the register file is held clear and ignores writes.
// - Bytes travel most significant bit first both ways.
// - Full duplex: status bits shift out while the command shifts in.
`timescale 1ns/1ps
`include "uph_defines.svh"

module uph_pins
  import uph_pkg::*;
#(
  parameter int unsigned INT_PULSE = `UPH_INT_PULSE_CYC
) (
  // Core clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // SPI link pins
  input  wire logic       i_sclk,
  input  wire logic       i_ss_n,
  input  wire logic       i_mosi_i,
  output logic            o_mosi_o,
  output logic            o_mosi_oe,
  output logic            o_miso_o,
  output logic            o_miso_oe,
  // Reset and supply pins
  input  wire logic       i_chip_clear_in_n,
  input  wire logic       i_supply_ok,
  input  wire logic       i_supply_compare_in,
  // General-purpose, mux and interrupt pins
  input  wire logic [3:0] i_gp_input_pins,
  output logic      [3:0] o_gp_output_pins,
  output logic            o_mux_status_out,
  output logic            o_int_o,
  output logic            o_int_oe,
  // USB core status, same clock domain
  input  wire logic       i_osc_ok,
  input  wire logic       i_bus_act,
  input  wire logic       i_sof,
  input  wire logic [7:0] i_usb_status
);

  localparam uph_rx_t RX_IDLE = '{first: 1'b1, default: '0};

  if (INT_PULSE < 1 || INT_PULSE > 255) begin : g_check
    $error("INT_PULSE must fit the 8-bit pulse counter");
  end

  uph_core_t core_q;
  uph_core_t core_d;
  uph_rx_t   rx_q;
  uph_rx_t   rx_d;
  uph_hs_t   hs_q;
  uph_hs_t   hs_d;
  uph_tx_t   tx_q;
  uph_tx_t   tx_d;

  logic       hold;
  logic       wr_evt;
  logic       pend;
  logic       pulse_act;
  logic       fdup;
  logic [7:0] hc_byte;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  uph_mux_t   mux_sel;

  function automatic logic [7:0] reg_read(input logic [4:0] a,
                                          input uph_snap_t  s);
    logic [7:0] v;
    v = '0;
    case (a)
      `UPH_REG_USB_IRQ:  v = s.usb_irq;
      `UPH_REG_USB_IEN:  v = s.usb_ien;
      `UPH_REG_BUS_CTL:  v = s.bus_ctl;
      `UPH_REG_HOST_CTL: v = s.host_ctl;
      `UPH_REG_PIN_CFG:  v = s.pin_cfg;
      `UPH_REG_IO_PINS:  v = s.io_pins;
      default:           v = '0;
    endcase
    return v;
  endfunction : reg_read

  // ---------------- Core domain ----------------

  assign hold    = ~core_q.clr_s[1] | ~core_q.sup_s[1];
  assign wr_evt  = core_q.wt_s[2] ^ core_q.wt_s[1];
  assign pend    = core_q.host_ie &
                   (|(core_q.usb_irq & core_q.usb_ien));
  assign pulse_act = core_q.host_ie && core_q.pcnt != '0;
  assign mux_sel = uph_mux_t'({core_q.pin_cfg[`UPH_PC_MUX_HI],
                               core_q.pin_cfg[`UPH_PC_MUX_LO]});

  always_comb begin
    core_d         = core_q;
    hc_byte        = '0;
    // Select, clear, supply and general input pins pass two flops before use
    core_d.ss_s    = {core_q.ss_s[0], i_ss_n};
    core_d.clr_s   = {core_q.clr_s[0], i_chip_clear_in_n};
    core_d.sup_s   = {core_q.sup_s[0], i_supply_ok};
    core_d.vb_s    = {core_q.vb_s[0], i_supply_compare_in};
    core_d.wt_s    = {core_q.wt_s[1:0], hs_q.tog};
    core_d.gi_a    = i_gp_input_pins;
    core_d.gi_b    = core_q.gi_a;
    core_d.vb_prev = core_q.vb_s[1];
    core_d.lnk_rst = i_rst;

    // Link data is stable for a whole byte after the toggle moves
    if (wr_evt && !hold) begin
      case (hs_q.addr)
        `UPH_REG_USB_IRQ:  core_d.usb_irq = core_q.usb_irq & ~hs_q.data;
        `UPH_REG_USB_IEN:  core_d.usb_ien = hs_q.data;
        `UPH_REG_BUS_CTL:  core_d.bus_ctl = hs_q.data;
        `UPH_REG_HOST_CTL: core_d.host_ie = hs_q.data[`UPH_HC_IE];
        `UPH_REG_PIN_CFG:  core_d.pin_cfg = hs_q.data;
        `UPH_REG_IO_PINS:  core_d.gpo = hs_q.data[`UPH_GPO_HI:0];
        default: ;
      endcase
    end

    // Supply edges set flags after the clear, so a set wins
    if (core_q.vb_s[1] && !core_q.vb_prev) begin
      core_d.usb_irq[`UPH_IRQ_VBUS] = 1'b1;
    end
    if (!core_q.vb_s[1] && core_q.vb_prev) begin
      core_d.usb_irq[`UPH_IRQ_NOVBUS] = 1'b1;
    end

    // Edge mode: one pulse of fixed width per new pending interrupt
    core_d.pend_prev = pend;
    if (pend && !core_q.pend_prev && !core_q.pin_cfg[`UPH_PC_LEVEL]) begin
      core_d.pcnt = INT_PULSE[`UPH_PCNT_W-1:0];
    end else if (core_q.pcnt != '0) begin
      core_d.pcnt = core_q.pcnt - `UPH_PCNT_ONE;
    end

    if (core_q.pin_cfg[`UPH_PC_LEVEL]) begin
      core_d.int_o  = 1'b0;
      core_d.int_oe = pend;
    end else begin
      core_d.int_oe = 1'b1;
      core_d.int_o  = core_q.pin_cfg[`UPH_PC_POSINT] ? pulse_act
                                                      : ~pulse_act;
    end

    unique case (mux_sel)
      MUX_OSC:    core_d.mux = i_osc_ok;
      MUX_SUPPLY: core_d.mux = core_q.vb_s[1];
      MUX_ACT:    core_d.mux = i_bus_act;
      MUX_SOF:    core_d.mux = i_sof;
    endcase

    // Snapshot refreshes only between frames, so the link reads a
    // byte that cannot change under it; writes made in the same
    // frame are not seen by reads of that frame
    hc_byte[`UPH_HC_IE]     = core_q.host_ie;
    hc_byte[`UPH_HC_SUPPLY] = core_q.vb_s[1];
    if (core_q.ss_s[1]) begin
      core_d.snap.status   = i_usb_status;
      core_d.snap.usb_irq  = core_q.usb_irq;
      core_d.snap.usb_ien  = core_q.usb_ien;
      core_d.snap.bus_ctl  = core_q.bus_ctl;
      core_d.snap.host_ctl = hc_byte;
      core_d.snap.pin_cfg  = core_q.pin_cfg;
      core_d.snap.io_pins  = {core_q.gi_b, core_q.gpo};
    end

    if (hold) begin
      core_d.usb_irq   = '0;
      core_d.usb_ien   = '0;
      core_d.host_ie   = 1'b0;
      core_d.gpo       = '0;
      core_d.pcnt      = '0;
      core_d.pend_prev = 1'b0;
      if (!core_q.sup_s[1]) begin
        core_d.pin_cfg = '0;
        core_d.bus_ctl = '0;
        core_d.snap    = '0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      core_q <= '{lnk_rst: 1'b1, default: '0};
    end else begin
      core_q <= core_d;
    end
  end

  assign o_gp_output_pins = core_q.gpo;
  assign o_mux_status_out = core_q.mux;
  assign o_int_o          = core_q.int_o;
  assign o_int_oe         = core_q.int_oe;

  // ---------------- Link domain ----------------

  assign fdup    = core_q.snap.pin_cfg[`UPH_PC_FDUP];
  assign rx_byte = {rx_q.sh, i_mosi_i};
  assign rd_byte = rx_q.first ? core_q.snap.status
                              : reg_read(rx_q.addr, core_q.snap);

  always_comb begin
    rx_d      = rx_q;
    hs_d      = hs_q;
    rx_d.sh   = rx_byte[6:0];
    rx_d.bitc = rx_q.bitc + `UPH_BIT_STEP;
    if (rx_q.bitc == `UPH_BIT_LAST) begin
      if (rx_q.first) begin
        rx_d.addr  = rx_byte[`UPH_CMD_ADDR_HI:`UPH_CMD_ADDR_LO];
        rx_d.dir   = rx_byte[`UPH_CMD_WR_BIT];
        rx_d.first = 1'b0;
      end else begin
        if (rx_q.dir) begin
          hs_d.tog  = ~hs_q.tog;
          hs_d.addr = rx_q.addr;
          hs_d.data = rx_byte;
        end
        // Control registers step on, stopping at the last one
        if (rx_q.addr > `UPH_REG_LAST_FIFO && rx_q.addr < `UPH_REG_LAST) begin
          rx_d.addr = rx_q.addr + `UPH_REG_STEP;
        end
      end
    end
  end

  // Slave-select high holds the framer idle and ignores the clock
  always_ff @(posedge i_sclk or posedge i_ss_n) begin
    if (i_ss_n) begin
      rx_q <= RX_IDLE;
    end else begin
      rx_q <= rx_d;
    end
  end

  // Write handoff survives frame ends; only full reset clears it
  always_ff @(posedge i_sclk or posedge core_q.lnk_rst) begin
    if (core_q.lnk_rst) begin
      hs_q <= '0;
    end else begin
      hs_q <= hs_d;
    end
  end

  always_comb begin
    tx_d      = tx_q;
    tx_d.dout = rd_byte[~rx_q.bitc];
    tx_d.oe   = ~rx_q.first & ~rx_q.dir & ~fdup;
  end

  always_ff @(negedge i_sclk or posedge i_ss_n) begin
    if (i_ss_n) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d;
    end
  end

  // The first status bit must be on the pin before any clock edge
  assign o_miso_o  = (rx_q.first && rx_q.bitc == `UPH_BIT_FIRST)
                     ? core_q.snap.status[`UPH_MSB] : tx_q.dout;
  assign o_miso_oe = ~i_ss_n & fdup;
  assign o_mosi_o  = tx_q.dout;
  assign o_mosi_oe = tx_q.oe & ~i_ss_n;

  // ---------------- Checks ----------------

  property p_mux_supply;
    @(posedge i_mclk) disable iff (i_rst)
      (mux_sel == MUX_SUPPLY) |=> (o_mux_status_out == $past(core_q.vb_s[1]));
  endproperty
  a_mux_supply: assert property (p_mux_supply)
    else $error("mux output does not show supply state");

  property p_gpo_write;
    @(posedge i_mclk) disable iff (i_rst)
      (wr_evt && !hold && hs_q.addr == `UPH_REG_IO_PINS)
      |=> (o_gp_output_pins == $past(hs_q.data[`UPH_GPO_HI:0]));
  endproperty
  a_gpo_write: assert property (p_gpo_write)
    else $error("general outputs missed a pin register write");

  property p_gpin_read;
    @(posedge i_mclk) disable iff (i_rst)
      (core_q.ss_s[1] && core_q.sup_s[1])
      |=> (core_q.snap.io_pins[`UPH_GPI_HI:`UPH_GPI_LO] == $past(core_q.gi_b));
  endproperty
  a_gpin_read: assert property (p_gpin_read)
    else $error("input bits do not show sampled pin levels");

  property p_ie_off;
    @(posedge i_mclk) disable iff (i_rst)
      (!core_q.host_ie) [*3]
      |-> (!o_int_oe || o_int_o == !$past(core_q.pin_cfg[`UPH_PC_POSINT]));
  endproperty
  a_ie_off: assert property (p_ie_off)
    else $error("interrupt pin active with enable clear");

  property p_level_od;
    @(posedge i_mclk) disable iff (i_rst)
      (core_q.pin_cfg[`UPH_PC_LEVEL] && $past(core_q.pin_cfg[`UPH_PC_LEVEL]))
      |-> (!o_int_o && o_int_oe == $past(pend));
  endproperty
  a_level_od: assert property (p_level_od)
    else $error("level mode pin not open-drain active low");

  property p_vbus_flag;
    @(posedge i_mclk) disable iff (i_rst)
      (core_q.vb_s[1] && !core_q.vb_prev && !hold)
      |=> core_q.usb_irq[`UPH_IRQ_VBUS];
  endproperty
  a_vbus_flag: assert property (p_vbus_flag)
    else $error("supply arrival flag not set");

  property p_clear_keeps;
    @(posedge i_mclk) disable iff (i_rst)
      (!core_q.clr_s[1] && core_q.sup_s[1])
      |=> ($stable(core_q.pin_cfg) && o_gp_output_pins == '0);
  endproperty
  a_clear_keeps: assert property (p_clear_keeps)
    else $error("chip clear touched pin config or kept outputs");

  property p_miso_release;
    @(posedge i_mclk) disable iff (i_rst)
      (i_ss_n || !fdup) |-> !o_miso_oe;
  endproperty
  a_miso_release: assert property (p_miso_release)
    else $error("MISO driven while deselected or half duplex");

  property p_cmd_done;
    @(posedge i_sclk) disable iff (i_ss_n)
      (rx_q.first && rx_q.bitc == `UPH_BIT_LAST)
      |=> (!rx_q.first && rx_q.bitc == `UPH_BIT_FIRST);
  endproperty
  a_cmd_done: assert property (p_cmd_done)
    else $error("command byte did not end after eight bits");

  property p_half_drive;
    @(negedge i_sclk) disable iff (i_ss_n)
      o_mosi_oe |-> (!fdup && !rx_q.dir && !rx_q.first);
  endproperty
  a_half_drive: assert property (p_half_drive)
    else $error("MOSI driven outside a half duplex read");

endmodule : uph_pins

//--- bench/uph_spi_master.sv
// SPI master model standing on the far side of the host pin block
`timescale 1ns/1ps

module uph_spi_master (
  // Link pins
  output logic      o_sclk,
  output logic      o_ss_n,
  output logic      o_mosi,
  // Device drive of the data pins
  input  wire logic i_mosi_o,
  input  wire logic i_mosi_oe,
  input  wire logic i_miso_o,
  input  wire logic i_miso_oe
);

  logic half;
  logic mval;
  logic miso_last;
  logic miso_seen;
  logic miso_w;

  // Released lines do not hold the last level: the simulator must not guess
  assign o_mosi = i_mosi_oe ? i_mosi_o : mval;
  assign miso_w = i_miso_oe ? i_miso_o : ~miso_last;

  always @(i_miso_o or i_miso_oe) begin
    if (i_miso_oe) begin
      miso_last = i_miso_o;
    end
  end

  // A short select at start-up gives the framer a clean rising edge
  initial begin
    o_sclk    = 1'b0;
    o_ss_n    = 1'b0;
    mval      = 1'b0;
    half      = 1'b1;
    miso_last = 1'b0;
    miso_seen = 1'b0;
    #1;
    o_ss_n    = 1'b1;
  end

  // Clock idles low; data set while low, both sides sample on the rise
  task automatic shift(input logic [7:0] tx, input logic rel,
                       output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mval = rel ? ~mval : tx[i];
      #3;
      rx[i] = half ? o_mosi : miso_w;
      miso_seen = miso_seen | i_miso_oe;
      o_sclk = 1'b1;
      #3;
      o_sclk = 1'b0;
    end
  endtask : shift

  task automatic frame(input logic [7:0] cmd, input logic [7:0] wd,
                       output logic [7:0] st, output logic [7:0] rd);
    o_ss_n = 1'b0;
    miso_seen = 1'b0;
    shift(cmd, 1'b0, st);
    shift(wd, half & ~cmd[1], rd);
    #3;
    o_ss_n = 1'b1;
    #20;
  endtask : frame

  // Stray clocks, with the slave selected or not; a partial byte when selected
  task automatic stray(input int n, input logic sel);
    o_ss_n = ~sel;
    for (int i = 0; i < n; i++) begin
      mval = ~mval;
      #3;
      o_sclk = 1'b1;
      #3;
      o_sclk = 1'b0;
    end
    #3;
    o_ss_n = 1'b1;
    #20;
  endtask : stray

endmodule : uph_spi_master

//--- bench/tb.sv
// Self-checking bench for the host pin block
`timescale 1ns/1ps

module tb;
  import uph_pkg::*;

  localparam int PW = 4;

  logic       i_mclk;
  logic       i_rst;
  logic       sclk, ss_n, mosi, mosi_o, mosi_oe, miso_o, miso_oe;
  logic       clr_n, sup_ok, sup_cmp, osc, act, sof;
  logic       mux, int_o, int_oe, int_w;
  logic [3:0] gpi, gpo;
  logic [7:0] ust, v, s, w, b;
  int         err_count, num_checks, n;

  // Open-drain interrupt line has a pull-up
  assign int_w = int_oe ? int_o : 1'b1;

  uph_pins #(.INT_PULSE(PW)) u_uph_pins (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(sclk), .i_ss_n(ss_n),
    .i_mosi_i(mosi), .o_mosi_o(mosi_o), .o_mosi_oe(mosi_oe),
    .o_miso_o(miso_o), .o_miso_oe(miso_oe), .i_chip_clear_in_n(clr_n),
    .i_supply_ok(sup_ok), .i_supply_compare_in(sup_cmp),
    .i_gp_input_pins(gpi), .o_gp_output_pins(gpo),
    .o_mux_status_out(mux), .o_int_o(int_o), .o_int_oe(int_oe),
    .i_osc_ok(osc), .i_bus_act(act), .i_sof(sof), .i_usb_status(ust)
  );

  uph_spi_master u_uph_spi_master (
    .o_sclk(sclk), .o_ss_n(ss_n), .o_mosi(mosi), .i_mosi_o(mosi_o),
    .i_mosi_oe(mosi_oe), .i_miso_o(miso_o), .i_miso_oe(miso_oe)
  );

  function automatic logic [7:0] cmd(input logic [4:0] a, input logic wr);
    return {a, 1'b0, wr, 1'($urandom_range(1))};
  endfunction : cmd

  function automatic logic [7:0] pins_exp(input logic [3:0] gi,
                                          input logic [7:0] wd);
    return {gi, wd[3:0]};
  endfunction : pins_exp

  function automatic logic mux_exp(input logic [1:0] sel,
                                   input logic [3:0] src);
    return src[sel];
  endfunction : mux_exp

  task automatic cyc(input int k);
    repeat (k) @(negedge i_mclk);
  endtask : cyc

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] st, rd;
    u_uph_spi_master.frame(cmd(a, 1'b1), d, st, rd);
    cyc(4);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] d,
                    output logic [7:0] st);
    u_uph_spi_master.frame(cmd(a, 1'b0), 8'h00, st, d);
    cyc(4);
  endtask : rd

  task automatic finish_test;
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  initial begin
    #400000;
    err_count++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h8A9E));
    {i_rst, clr_n, sup_ok, sup_cmp, osc, act, sof} = 7'h74;
    gpi = 4'h0;
    ust = 8'h00;
    err_count = 0;
    num_checks = 0;
    repeat (12) @(negedge i_mclk);
    i_rst = 1'b0;
    cyc(6);
    chk({7'h00, mux}, 8'h01);
    wr(5'h11, 8'h10);
    u_uph_spi_master.half = 1'b0;
    // Pin register: output bits follow writes, input bits show the pins
    for (int k = 0; k < 4; k++) begin
      w = (k == 0) ? 8'hF0 : 8'($urandom);
      gpi = 4'($urandom);
      ust = 8'($urandom);
      wr(5'h14, w);
      chk({4'h0, gpo}, {4'h0, w[3:0]});
      rd(5'h14, v, s);
      chk(v, pins_exp(gpi, w));
      chk(s, ust);
      chk({7'h00, u_uph_spi_master.miso_seen}, 8'h01);
    end
    for (int k = 0; k < 8; k++) begin
      {osc, sup_cmp, act, sof} = 4'($urandom);
      wr(5'h11, {6'h04, k[1:0]});
      cyc(4);
      chk({7'h00, mux},
          {7'h00, mux_exp(k[1:0], {sof, act, sup_cmp, osc})});
    end
    // Level mode: enabled supply-arrival event, pin enable off then on
    sup_cmp = 1'b0;
    wr(5'h0E, 8'h40);
    wr(5'h11, 8'h18);
    cyc(6);
    wr(5'h0D, 8'hFF);
    sup_cmp = 1'b1;
    cyc(8);
    chk({6'h00, int_oe, int_w}, 8'h01);
    rd(5'h0D, v, s);
    chk(v, 8'h40);
    wr(5'h10, 8'h01);
    cyc(2);
    chk({6'h00, int_oe, int_w}, 8'h02);
    rd(5'h10, v, s);
    chk(v, 8'h81);
    wr(5'h0D, 8'h40);
    cyc(2);
    chk({6'h00, int_oe, int_w}, 8'h01);
    // Edge mode, active high: idle low, one pulse of fixed width
    wr(5'h11, 8'h14);
    sup_cmp = 1'b0;
    cyc(6);
    wr(5'h0D, 8'hFF);
    cyc(2);
    chk({6'h00, int_oe, int_w}, 8'h02);
    sup_cmp = 1'b1;
    for (n = 0; n < 20 && int_w !== 1'b1; n++) cyc(1);
    if (int_w !== 1'b1) begin
      err_count++;
    end
    for (n = 0; n < 20 && int_w === 1'b1; n++) cyc(1);
    chk(n[7:0], PW[7:0]);
    wr(5'h0D, 8'h40);
    wr(5'h11, 8'h10);
    cyc(2);
    chk({6'h00, int_oe, int_w}, 8'h03);
    // Chip clear keeps pin config and bus control only
    b = 8'($urandom);
    wr(5'h0F, b);
    wr(5'h14, 8'h0F);
    clr_n = 1'b0;
    cyc(6);
    clr_n = 1'b1;
    cyc(6);
    chk({4'h0, gpo}, 8'h00);
    rd(5'h11, v, s);
    chk(v, 8'h10);
    rd(5'h0F, v, s);
    chk(v, b);
    rd(5'h10, v, s);
    chk(v, 8'h80);
    // Stray clocks while deselected, then a cut-short frame
    u_uph_spi_master.stray(5, 1'b0);
    u_uph_spi_master.stray(3, 1'b1);
    wr(5'h14, 8'h0A);
    chk({4'h0, gpo}, 8'h0A);
    // Supply absent: held in reset, writes lost
    sup_ok = 1'b0;
    cyc(6);
    wr(5'h14, 8'h05);
    chk({4'h0, gpo}, 8'h00);
    sup_ok = 1'b1;
    cyc(6);
    u_uph_spi_master.half = 1'b1;
    rd(5'h14, v, s);
    chk(v, {gpi, 4'h0});
    chk({7'h00, u_uph_spi_master.miso_seen}, 8'h00);
    finish_test();
  end

endmodule : tb
